/* rtl/mnc_pkg.sv */
package mnc_pkg;
    // ======================================================
    // register map
    localparam logic [7:0] MNC_OFF_NET_CTRL   = 8'h00;
    localparam logic [7:0] MNC_OFF_NET_STATUS = 8'h01;
    localparam logic [7:0] MNC_OFF_TX_CTRL    = 8'h02;
    // ======================================================
    // network control fields
    localparam int MNC_NC_SOFT_RESET  = 0;
    localparam int MNC_NC_LOOP_LO     = 1;
    localparam int MNC_NC_DUPLEX      = 3;
    localparam int MNC_NC_WAKE_NOTIFY = 4;
    localparam int MNC_NC_WAKE_EN     = 6;
    // ======================================================
    // network status fields
    localparam int MNC_NS_RX_READY   = 0;
    localparam int MNC_NS_RX_OVF     = 1;
    localparam int MNC_NS_TX_DONE_A  = 2;
    localparam int MNC_NS_TX_DONE_B  = 3;
    localparam int MNC_NS_WAKE_EVENT = 5;
    localparam int MNC_NS_LINK_UP    = 6;
    localparam int MNC_NS_SPEED_10   = 7;
    // ======================================================
    // transmit control fields
    localparam int MNC_TC_TX_REQ     = 0;
    localparam int MNC_TC_FCS_DIS_A  = 1;
    localparam int MNC_TC_PAD_DIS_A  = 2;
    localparam int MNC_TC_FCS_DIS_B  = 3;
    localparam int MNC_TC_PAD_DIS_B  = 4;
    localparam int MNC_TC_JABBER_DIS = 6;
    // ======================================================
    // reset values and encodings
    localparam logic [1:0] MNC_LOOP_NORMAL   = 2'h0;
    localparam logic [1:0] MNC_LOOP_MAC      = 2'h1;
    localparam logic       MNC_TX_DONE_RST   = 1'h1;
    // ======================================================
    // timing and frame figures
    localparam int MNC_CLK_MHZ         = 25;
    localparam int MNC_SOFT_RESET_US   = 10;
    localparam int MNC_SOFT_RESET_CYC  = MNC_SOFT_RESET_US * MNC_CLK_MHZ;
    localparam int MNC_JABBER_BYTES    = 2048;
    localparam int MNC_MIN_FRAME_BYTES = 64;
    localparam int MNC_FCS_BYTES       = 4;
endpackage

/* rtl/mnc_ctrl.sv */
`timescale 1ns/1ns
// Function
// - soft reset bit self-clears after 10us
// - wake enable; clearing wipes wake events
// - loopback field: 00 normal, 01 MAC
// - duplex indicator reports PHY duplex
// - speed bit: one means 10 Mbit/s
// - link bit reports PHY link state
// - wake flag sets on event, read/W1 clears
// - index B done clears at start, sets end
// - index A done clears at start, sets end
// - overflow flag reports receive memory overflow
// - ready flag reports packet held in memory
// - jabber timer 2048 bytes, disable bit
// - per-index pad disable bits
// - per-index FCS disable bits
// - transmit request self-clears after send
// - soft reset restores software-reset defaults only
module mnc_ctrl (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // phy and receive memory state, from pins
    input  wire logic       phy_link_up,
    input  wire logic       phy_speed_10,
    input  wire logic       phy_full_duplex,
    input  wire logic       rx_mem_overflow,
    input  wire logic       rx_mem_ready,
    input  wire logic       wake_event,
    // transmit engine handshake, same clock
    input  wire logic       tx_byte_strobe,
    input  wire logic       tx_frame_end,
    input  wire logic       tx_use_second_index,
    // controls to the mac
    output logic            soft_reset_active,
    output logic      [1:0] loopback_select,
    output logic            wake_frame_notify_toggle,
    output logic            wake_function_enable,
    output logic            tx_start,
    output logic            tx_active_index_b,
    output logic            tx_pad_enable,
    output logic            tx_fcs_enable,
    output logic            tx_jabber_abort
);
    import mnc_pkg::*;

    // ======================================================
    // input synchronisers: three stages, change counts when stages two and three agree
    logic [5:0] sync1_ff, sync2_ff, sync3_ff, filt_ff;
    logic [5:0] nxt_filt;
    assign nxt_filt = (sync2_ff == sync3_ff) ? sync3_ff : filt_ff;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
            sync3_ff <= 6'h00;
            filt_ff  <= 6'h00;
        end else begin
            sync1_ff <= {wake_event, rx_mem_ready, rx_mem_overflow, phy_full_duplex, phy_speed_10, phy_link_up};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff  <= nxt_filt;
        end
    end
    wire link_s   = filt_ff[0];
    wire speed_s  = filt_ff[1];
    wire duplex_s = filt_ff[2];
    wire ovf_s    = filt_ff[3];
    wire ready_s  = filt_ff[4];
    wire wake_s   = filt_ff[5];
    logic wake_prev_ff;

    // ======================================================
    // decode
    wire wr_nc = reg_wr && (reg_addr == MNC_OFF_NET_CTRL);
    wire wr_ns = reg_wr && (reg_addr == MNC_OFF_NET_STATUS);
    wire wr_tc = reg_wr && (reg_addr == MNC_OFF_TX_CTRL);
    wire rd_ns = reg_rd && (reg_addr == MNC_OFF_NET_STATUS);

    // ======================================================
    // soft reset timer
    localparam int CNT_W = $clog2(MNC_SOFT_RESET_CYC + 1);
    logic [CNT_W-1:0] srst_cnt_ff;
    logic             srst_ff;
    wire srst_req  = wr_nc && reg_wdata[MNC_NC_SOFT_RESET];
    wire srst_done = srst_ff && (srst_cnt_ff == CNT_W'(MNC_SOFT_RESET_CYC - 1));
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            srst_ff     <= 1'b0;
            srst_cnt_ff <= '0;
        end else if (srst_req && !srst_ff) begin
            srst_ff     <= 1'b1;
            srst_cnt_ff <= '0;
        end else if (srst_done) begin
            srst_ff     <= 1'b0;
        end else if (srst_ff) begin
            srst_cnt_ff <= srst_cnt_ff + 1'b1;
        end
    end

    // ======================================================
    // network control: enable is power-on only, others also cleared by soft reset
    logic       wake_en_ff, notify_ff;
    logic [1:0] loop_ff;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wake_en_ff <= 1'b0;
            notify_ff  <= 1'b0;
            loop_ff    <= MNC_LOOP_NORMAL;
        end else begin
            if (wr_nc)
                wake_en_ff <= reg_wdata[MNC_NC_WAKE_EN];
            if (srst_ff) begin
                notify_ff <= 1'b0;
                loop_ff   <= MNC_LOOP_NORMAL;
            end else if (wr_nc) begin
                notify_ff <= reg_wdata[MNC_NC_WAKE_NOTIFY];
                loop_ff   <= reg_wdata[MNC_NC_LOOP_LO +: 2];
            end
        end
    end

    // ======================================================
    // wake event flag: set wins over clear, survives soft reset
    logic wake_flag_ff;
    wire  wake_set = wake_en_ff && wake_s && !wake_prev_ff;
    wire  wake_clr = rd_ns || (wr_ns && reg_wdata[MNC_NS_WAKE_EVENT]) || (wr_nc && !reg_wdata[MNC_NC_WAKE_EN]);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wake_flag_ff <= 1'b0;
            wake_prev_ff <= 1'b0;
        end else begin
            wake_prev_ff <= wake_s;
            if (wake_set)
                wake_flag_ff <= 1'b1;
            else if (wake_clr)
                wake_flag_ff <= 1'b0;
        end
    end

    // ======================================================
    // transmit control and request
    logic pad_dis_a_ff, pad_dis_b_ff, fcs_dis_a_ff, fcs_dis_b_ff, jab_dis_ff;
    logic tx_req_ff, tx_idx_b_ff, start_ff;
    wire  tx_go = wr_tc && reg_wdata[MNC_TC_TX_REQ] && !tx_req_ff && !srst_ff;
    logic [11:0] byte_cnt_ff;
    wire  jab_hit = !jab_dis_ff && tx_req_ff && tx_byte_strobe &&
                    (byte_cnt_ff == 12'(MNC_JABBER_BYTES - 1));
    wire  tx_end  = tx_req_ff && (tx_frame_end || jab_hit);
    always_ff @(posedge sys_clk) begin
        if (rst || srst_ff) begin
            pad_dis_a_ff <= 1'b0;
            pad_dis_b_ff <= 1'b0;
            fcs_dis_a_ff <= 1'b0;
            fcs_dis_b_ff <= 1'b0;
            jab_dis_ff   <= 1'b0;
            tx_req_ff    <= 1'b0;
            tx_idx_b_ff  <= 1'b0;
            start_ff     <= 1'b0;
            byte_cnt_ff  <= 12'h000;
        end else begin
            start_ff <= tx_go;
            if (wr_tc) begin
                pad_dis_a_ff <= reg_wdata[MNC_TC_PAD_DIS_A];
                pad_dis_b_ff <= reg_wdata[MNC_TC_PAD_DIS_B];
                fcs_dis_a_ff <= reg_wdata[MNC_TC_FCS_DIS_A];
                fcs_dis_b_ff <= reg_wdata[MNC_TC_FCS_DIS_B];
                jab_dis_ff   <= reg_wdata[MNC_TC_JABBER_DIS];
            end
            if (tx_go) begin
                tx_req_ff   <= 1'b1;
                tx_idx_b_ff <= tx_use_second_index;
                byte_cnt_ff <= 12'h000;
            end else if (tx_end) begin
                tx_req_ff   <= 1'b0;
            end else if (tx_req_ff && tx_byte_strobe) begin
                byte_cnt_ff <= byte_cnt_ff + 12'h001;
            end
        end
    end

    // ======================================================
    // completion flags: reset to one; end-of-send set beats write-one clear
    logic done_a_ff, done_b_ff;
    wire  clr_a = wr_ns && reg_wdata[MNC_NS_TX_DONE_A];
    wire  clr_b = wr_ns && reg_wdata[MNC_NS_TX_DONE_B];
    always_ff @(posedge sys_clk) begin
        if (rst || srst_ff) begin
            done_a_ff <= MNC_TX_DONE_RST;
            done_b_ff <= MNC_TX_DONE_RST;
        end else begin
            if (tx_end && !tx_idx_b_ff)
                done_a_ff <= 1'b1;
            else if ((tx_go && !tx_use_second_index) || clr_a)
                done_a_ff <= 1'b0;
            if (tx_end && tx_idx_b_ff)
                done_b_ff <= 1'b1;
            else if ((tx_go && tx_use_second_index) || clr_b)
                done_b_ff <= 1'b0;
        end
    end

    // ======================================================
    // read mux; reserved bits read as zero
    wire [7:0] nc_val = {1'b0, wake_en_ff, 1'b0, notify_ff, duplex_s, loop_ff, srst_ff};
    wire [7:0] ns_val = {speed_s, link_s, wake_flag_ff, 1'b0, done_b_ff, done_a_ff,
                         ovf_s, ready_s};
    wire [7:0] tc_val = {1'b0, jab_dis_ff, 1'b0, pad_dis_b_ff, fcs_dis_b_ff,
                         pad_dis_a_ff, fcs_dis_a_ff, tx_req_ff};
    wire [7:0] rd_mux = (reg_addr == MNC_OFF_NET_CTRL)   ? nc_val :
                        (reg_addr == MNC_OFF_NET_STATUS) ? ns_val :
                        (reg_addr == MNC_OFF_TX_CTRL)    ? tc_val : 8'h00;

    // ======================================================
    // registered outputs
    wire sel_b = tx_go ? tx_use_second_index : tx_idx_b_ff;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata                <= 8'h00;
            soft_reset_active        <= 1'b0;
            loopback_select          <= MNC_LOOP_NORMAL;
            wake_frame_notify_toggle <= 1'b0;
            wake_function_enable     <= 1'b0;
            tx_start                 <= 1'b0;
            tx_active_index_b        <= 1'b0;
            tx_pad_enable            <= 1'b1;
            tx_fcs_enable            <= 1'b1;
            tx_jabber_abort          <= 1'b0;
        end else begin
            reg_rdata                <= reg_rd ? rd_mux : 8'h00;
            soft_reset_active        <= srst_ff;
            loopback_select          <= loop_ff;
            wake_frame_notify_toggle <= notify_ff;
            wake_function_enable     <= wake_en_ff;
            tx_start                 <= tx_go;
            tx_active_index_b        <= sel_b;
            // the engine pads to the 64-byte minimum and adds a 4-byte check sequence
            tx_pad_enable            <= sel_b ? !pad_dis_b_ff : !pad_dis_a_ff;
            tx_fcs_enable            <= sel_b ? !fcs_dis_b_ff : !fcs_dis_a_ff;
            tx_jabber_abort          <= jab_hit;
        end
    end

    // ======================================================
    // checks
    chk_srst_len: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(srst_ff) |-> srst_ff [*8]) else $error("soft reset ended early");
    chk_srst_total: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(srst_ff) |-> $past(srst_cnt_ff) == CNT_W'(MNC_SOFT_RESET_CYC - 1)) else $error("soft reset length");
    chk_wake_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_nc && !reg_wdata[MNC_NC_WAKE_EN] && !wake_set) |=> !wake_flag_ff) else $error("wake flag kept");
    chk_wake_en_keep: assert property (@(posedge sys_clk) disable iff (rst)
        (srst_ff && !wr_nc) |=> $stable(wake_en_ff)) else $error("wake enable lost in soft reset");
    chk_wake_read: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_ns && !wake_set) |=> !wake_flag_ff) else $error("wake flag not cleared by read");
    chk_flag_keep: assert property (@(posedge sys_clk) disable iff (rst)
        (srst_ff && wake_flag_ff && !wake_clr) |=> wake_flag_ff) else $error("wake flag lost in soft reset");
    chk_done_a: assert property (@(posedge sys_clk) disable iff (rst || srst_ff)
        (tx_go && !tx_use_second_index) |=> !done_a_ff until tx_end) else $error("done A set early");
    chk_done_a_set: assert property (@(posedge sys_clk) disable iff (rst)
        (tx_end && !tx_idx_b_ff) |=> done_a_ff) else $error("done A not set");
    chk_done_b: assert property (@(posedge sys_clk) disable iff (rst || srst_ff)
        (tx_end && tx_idx_b_ff) |=> done_b_ff) else $error("done B not set");
    chk_done_b_clr: assert property (@(posedge sys_clk) disable iff (rst)
        (tx_go && tx_use_second_index) |=> !done_b_ff) else $error("done B not cleared at start");
    chk_transmit_request_end: assert property (@(posedge sys_clk) disable iff (rst || srst_ff)
        tx_end |=> !tx_req_ff) else $error("request not cleared");
    chk_transmit_request_set: assert property (@(posedge sys_clk) disable iff (rst)
        tx_go |=> tx_req_ff && tx_start) else $error("request not started");
    chk_tx_refused: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_tc && reg_wdata[MNC_TC_TX_REQ] && tx_req_ff) |=> !tx_start) else $error("busy request restarted");
    chk_jabber_cut: assert property (@(posedge sys_clk) disable iff (rst)
        jab_hit |=> tx_jabber_abort && !tx_req_ff) else $error("jabber not enforced");
    chk_loop_srst: assert property (@(posedge sys_clk) disable iff (rst)
        srst_ff |=> loop_ff == MNC_LOOP_NORMAL && done_a_ff) else $error("soft reset default lost");
    chk_loop_write: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_nc && !srst_ff) |=> loop_ff == $past(reg_wdata[MNC_NC_LOOP_LO +: 2])) else $error("loopback not stored");
    chk_pad_sel: assert property (@(posedge sys_clk) disable iff (rst)
        (!tx_go && !tx_idx_b_ff) |=> tx_pad_enable == !$past(pad_dis_a_ff)) else $error("pad select wrong");
    chk_fcs_sel: assert property (@(posedge sys_clk) disable iff (rst)
        (!tx_go && tx_idx_b_ff) |=> tx_fcs_enable == !$past(fcs_dis_b_ff)) else $error("fcs select wrong");

    // ======================================================
    // checks: read data against the synchronised pin state
    chk_link_read: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ns |=> reg_rdata[MNC_NS_LINK_UP] == $past(link_s)) else $error("link bit wrong");
    chk_speed_read: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ns |=> reg_rdata[MNC_NS_SPEED_10] == $past(speed_s)) else $error("speed bit wrong");
    chk_ovf_read: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ns |=> reg_rdata[MNC_NS_RX_OVF] == $past(ovf_s)) else $error("overflow bit wrong");
    chk_ready_read: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ns |=> reg_rdata[MNC_NS_RX_READY] == $past(ready_s)) else $error("ready bit wrong");
    chk_duplex_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == MNC_OFF_NET_CTRL) |=> reg_rdata[MNC_NC_DUPLEX] == $past(duplex_s))
        else $error("duplex bit wrong");
endmodule // mnc_ctrl

/* tb/mnc_tx_engine_model.sv */
`timescale 1ns/1ns
// ======================================================
// transmit engine stand-in: one byte per cycle, then a frame end pulse
module mnc_tx_engine_model (
    // clock
    input  wire logic        sys_clk,
    // handshake with the control block
    input  wire logic        tx_start,
    input  wire logic        tx_jabber_abort,
    input  wire logic [15:0] frame_len,
    output logic             tx_byte_strobe,
    output logic             tx_frame_end
);
    logic [15:0] left_ff = 16'h0;
    logic        busy_ff = 1'b0;
    always @(posedge sys_clk) begin
        tx_byte_strobe <= 1'b0;
        tx_frame_end   <= 1'b0;
        if (tx_start) begin
            left_ff <= frame_len;
            busy_ff <= 1'b1;
        end else if (busy_ff && tx_jabber_abort) begin
            // truncated frame still closes with a frame end
            left_ff      <= 16'h0;
            busy_ff      <= 1'b0;
            tx_frame_end <= 1'b1;
        end else if (busy_ff && left_ff != 16'h0) begin
            tx_byte_strobe <= 1'b1;
            left_ff        <= left_ff - 16'h1;
        end else if (busy_ff) begin
            busy_ff      <= 1'b0;
            tx_frame_end <= 1'b1;
        end
    end
endmodule // mnc_tx_engine_model

/* tb/test_mnc_ctrl.sv */
`timescale 1ns/1ns
module test_mnc_ctrl;
    import mnc_pkg::*;
    localparam logic [7:0] MNC_OFF_DEAD = 8'h3C;
    // ======================================================
    // stimulus and observation
    logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, d;
    logic phy_link_up = 1'b0, phy_speed_10 = 1'b0, phy_full_duplex = 1'b0;
    logic rx_mem_overflow = 1'b0, rx_mem_ready = 1'b0, wake_event = 1'b0, tx_use_second_index = 1'b0;
    logic [15:0] frame_len = 16'h0;
    wire logic [7:0] reg_rdata;
    wire logic [1:0] loopback_select;
    wire logic tx_byte_strobe, tx_frame_end, soft_reset_active, wake_frame_notify_toggle;
    wire logic wake_function_enable, tx_start, tx_active_index_b, tx_pad_enable, tx_fcs_enable, tx_jabber_abort;
    int failures = 0, checked = 0, seed = 18190, cnt = 0, bytes = 0, jab = 0, n;
    logic [31:0] r;
    logic b;
    logic [1:0] dn;
    always #20 sys_clk = ~sys_clk;
    mnc_ctrl mnc_ctrl_inst (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .phy_link_up, .phy_speed_10, .phy_full_duplex, .rx_mem_overflow, .rx_mem_ready, .wake_event,
        .tx_byte_strobe, .tx_frame_end, .tx_use_second_index, .soft_reset_active, .loopback_select,
        .wake_frame_notify_toggle, .wake_function_enable, .tx_start, .tx_active_index_b,
        .tx_pad_enable, .tx_fcs_enable, .tx_jabber_abort);
    mnc_tx_engine_model mnc_tx_engine_model_inst (.sys_clk, .tx_start, .tx_jabber_abort, .frame_len,
        .tx_byte_strobe, .tx_frame_end);
    // bytes sent before the abort, counted from the start pulse
    always @(posedge sys_clk) begin
        if (tx_jabber_abort) jab = bytes;
        if (tx_start) begin
            bytes = 0;
            jab = 0;
        end else if (tx_byte_strobe) bytes++;
    end
    // ======================================================
    // bus cycles and comparison
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // registered outputs follow a write one edge later
    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse_wake();
        wake_event <= 1'b1; repeat (8) @(posedge sys_clk);
        wake_event <= 1'b0; repeat (8) @(posedge sys_clk);
    endtask
    task automatic wait_end();
        n = 0;
        while (tx_frame_end !== 1'b1 && n < 4000) begin @(posedge sys_clk); #1 n++; end
        chk(16'(n < 4000), 16'h1);
        repeat (2) @(posedge sys_clk);
    endtask
    // index in use decides which pad, fcs and done bits apply
    function automatic logic [15:0] exp_dis(input logic [31:0] v, input logic bi, input int lo);
        return 16'(!(bi ? v[lo + 2] : v[lo]));
    endfunction
    initial begin #(40 * 20000); failures++; close_out(); end
    // ======================================================
    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rdr(MNC_OFF_NET_CTRL, d); chk(d & 8'h5F, 8'h00);
        rdr(MNC_OFF_TX_CTRL, d); chk(d & 8'h5F, 8'h00);
        repeat (4) begin
            r = $random(seed);
            {phy_speed_10, phy_link_up, phy_full_duplex, rx_mem_overflow, rx_mem_ready} <= r[4:0];
            repeat (8) @(posedge sys_clk);
            rdr(MNC_OFF_NET_STATUS, d);
            chk(d & 8'hEF, {r[4], r[3], 4'h3, r[1:0]});
            rdr(MNC_OFF_NET_CTRL, d); chk(d[3], r[2]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(MNC_OFF_NET_CTRL, 8'(8'h40 | (i << 1)));
            settle();
            chk(loopback_select, 16'(i));
            chk(wake_function_enable, 16'h1);
        end
        rdr(MNC_OFF_NET_CTRL, d); wr(MNC_OFF_NET_CTRL, (d & 8'h56) ^ 8'h10);
        settle();
        chk(wake_frame_notify_toggle, 16'(!d[4]));
        pulse_wake(); rdr(MNC_OFF_NET_STATUS, d); chk(d[5], 16'h1);
        rdr(MNC_OFF_NET_STATUS, d); chk(d[5], 16'h0);
        pulse_wake(); wr(MNC_OFF_NET_STATUS, 8'h20); rdr(MNC_OFF_NET_STATUS, d); chk(d[5], 16'h0);
        pulse_wake(); wr(MNC_OFF_NET_CTRL, 8'h00); rdr(MNC_OFF_NET_STATUS, d); chk(d[5], 16'h0);
        wr(MNC_OFF_NET_CTRL, 8'h40); pulse_wake();
        wr(MNC_OFF_TX_CTRL, 8'h5E);
        wr(MNC_OFF_NET_CTRL, 8'h43);
        settle();
        cnt = 0;
        while (soft_reset_active === 1'b1 && cnt < 1000) begin @(posedge sys_clk); #1 cnt++; end
        chk(16'(cnt), 16'(MNC_SOFT_RESET_CYC));
        rdr(MNC_OFF_NET_CTRL, d); chk(d & 8'h57, 8'h40);
        rdr(MNC_OFF_TX_CTRL, d); chk(d & 8'h5F, 8'h00);
        rdr(MNC_OFF_NET_STATUS, d); chk(d[5], 16'h1);
        wr(MNC_OFF_NET_STATUS, 8'hFF); wr(MNC_OFF_DEAD, 8'hFF); rdr(MNC_OFF_DEAD, d); chk(d, 8'h00);
        rdr(MNC_OFF_NET_STATUS, d); chk(d[3:2], 16'h0);
        dn = 2'b00;
        repeat (8) begin
            r = $random(seed);
            b = r[8];
            dn[b] = 1'b0;
            tx_use_second_index <= b; frame_len <= 16'(10 + r[13:9]);
            wr(MNC_OFF_TX_CTRL, {1'b0, 1'b1, 1'b0, r[4:1], 1'b1});
            chk(tx_start, 16'h1);
            chk(tx_active_index_b, 16'(b));
            rdr(MNC_OFF_TX_CTRL, d); chk(d[0], 16'h1);
            chk(tx_pad_enable, exp_dis(r, b, 2));
            chk(tx_fcs_enable, exp_dis(r, b, 1));
            rdr(MNC_OFF_NET_STATUS, d); chk(d[3:2], 16'(dn));
            wait_end();
            dn[b] = 1'b1;
            rdr(MNC_OFF_TX_CTRL, d); chk(d[0], 16'h0);
            rdr(MNC_OFF_NET_STATUS, d); chk(d[3:2], 16'(dn));
        end
        frame_len <= 16'd2100;
        wr(MNC_OFF_TX_CTRL, 8'h01); wait_end(); chk(16'(jab), 16'(MNC_JABBER_BYTES));
        wr(MNC_OFF_TX_CTRL, 8'h41); wait_end(); chk(16'(jab), 16'h0);
        close_out();
    end
endmodule // test_mnc_ctrl
